// ===== rtl/tcc_pkg.sv
// Package with register map, field layout and mode codes of the three channel capture block.
package tcc_pkg;
    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] TCC_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] TCC_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] TCC_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] TCC_OFF_BUF0 = 8'h0C;
    localparam logic [7:0] TCC_OFF_BUF1 = 8'h10;
    localparam logic [7:0] TCC_OFF_BUF2 = 8'h14;
    localparam logic [7:0] TCC_OFF_STAT = 8'h18;
    localparam int TCC_ADDR_W = 8;
    // ==================================================================
    // Field layout
    localparam int TCC_NCH = 3;
    localparam int TCC_TB_W = 16;
    localparam int TCC_CTRL_REN_BIT = 6;
    localparam int TCC_CTRL_MODE_LSB = 0;
    localparam int TCC_STAT_FLAG_LSB = 0;
    localparam int TCC_STAT_VALID_LSB = 4;
    localparam logic [3:0] TCC_MODE_RESET = 4'h0;
    localparam logic TCC_REN_RESET = 1'b0;
    localparam logic [3:0] TCC_PRESC_RESET = 4'h0;
    localparam logic [1:0] TCC_DIV4_LAST = 2'h3;
    localparam logic [3:0] TCC_DIV16_LAST = 4'hF;
    // ==================================================================
    // Mode codes
    localparam logic [3:0] TCC_M_OFF = 4'h0;
    localparam logic [3:0] TCC_M_FALL = 4'h1;
    localparam logic [3:0] TCC_M_RISE = 4'h2;
    localparam logic [3:0] TCC_M_DIV4 = 4'h3;
    localparam logic [3:0] TCC_M_DIV16 = 4'h4;
    localparam logic [3:0] TCC_M_PERIOD = 4'h5;
    localparam logic [3:0] TCC_M_PW_FR = 4'h6;
    localparam logic [3:0] TCC_M_PW_RF = 4'h7;
    localparam logic [3:0] TCC_M_CHANGE = 4'h8;
    localparam logic [3:0] TCC_M_SPEC_FALL = 4'hE;
    localparam logic [3:0] TCC_M_SPEC_RISE = 4'hF;
    // ==================================================================
    // AHB-Lite encodings
    localparam logic [1:0] TCC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TCC_HTRANS_SEQ = 2'h3;
    localparam logic TCC_HRESP_OKAY = 1'b0;
    // Pulse width tracking per channel.
    typedef enum logic [0:0] {
        TCC_PW_FIRST = 1'b0,
        TCC_PW_ARMED = 1'b1
    } tcc_pw_t;
endpackage

// ===== rtl/tcc_capture.sv
// Three channel input capture block with an AHB-Lite register slave.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module tcc_capture (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Capture pins
    input wire logic [tcc_pkg::TCC_NCH-1:0] capture_input_i,
    // Shared time base counter
    input wire logic [tcc_pkg::TCC_TB_W-1:0] capture_time_base_i,
    input wire logic time_base_write_i,
    output logic time_base_reset_o,
    // Event outputs
    output logic [tcc_pkg::TCC_NCH-1:0] capture_event_o,
    output logic special_event_o
);
    import tcc_pkg::*;

    // ==================================================================
    // Declarations
    logic [TCC_NCH-1:0] pin_meta_reg;
    logic [TCC_NCH-1:0] pin_sync_reg;
    logic [TCC_NCH-1:0] pin_prev_reg;
    logic primed_reg;
    logic [TCC_NCH-1:0] rise;
    logic [TCC_NCH-1:0] fall;
    logic [3:0] mode_reg [TCC_NCH];
    logic [TCC_NCH-1:0] ren_reg;
    logic [TCC_TB_W-1:0] buf_reg [TCC_NCH];
    logic [3:0] presc_reg [TCC_NCH];
    tcc_pw_t pw_reg [TCC_NCH];
    logic [TCC_NCH-1:0] seen_reg;
    logic [TCC_NCH-1:0] valid_reg;
    logic [TCC_NCH-1:0] flag_reg;
    logic [TCC_NCH-1:0] cap_evt;
    logic [TCC_NCH-1:0] rst_req;
    logic [TCC_NCH-1:0] init_edge;
    logic [TCC_NCH-1:0] ctrl_wr;
    logic spec_evt;
    logic wr_pend_reg;
    logic [TCC_ADDR_W-1:0] wr_addr_reg;
    logic addr_phase;
    logic [31:0] rd_next;

    // Maps a channel index to its control register offset.
    function automatic logic [TCC_ADDR_W-1:0] tcc_ctrl_off(input int ch);
        logic [TCC_ADDR_W-1:0] off;
        off = TCC_OFF_CTRL0;
        case (ch)
            1: off = TCC_OFF_CTRL1;
            2: off = TCC_OFF_CTRL2;
            default: off = TCC_OFF_CTRL0;
        endcase
        return off;
    endfunction

    function automatic logic tcc_is_pw(input logic [3:0] mode);
        return (mode == TCC_M_PW_FR) || (mode == TCC_M_PW_RF);
    endfunction

    // ==================================================================
    // Pin synchronisers and edge detection
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_prev_reg <= '0;
            primed_reg <= 1'b0;
        end else begin
            pin_meta_reg <= capture_input_i;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
            primed_reg <= 1'b1;
        end
    end

    // The first cycle after reset is skipped, yet a start-up high level still shows as a rising edge once it leaves the synchroniser.
    assign rise = primed_reg ? (pin_sync_reg & ~pin_prev_reg) : '0;
    assign fall = primed_reg ? (~pin_sync_reg & pin_prev_reg) : '0;

    // ==================================================================
    // Event decode
    always_comb begin
        cap_evt = '0;
        rst_req = '0;
        init_edge = '0;
        spec_evt = 1'b0;
        for (int i = 0; i < TCC_NCH; i++) begin
            case (mode_reg[i])
                TCC_M_OFF: cap_evt[i] = 1'b0;
                TCC_M_FALL: cap_evt[i] = fall[i];
                TCC_M_RISE: cap_evt[i] = rise[i];
                TCC_M_DIV4: cap_evt[i] = rise[i] && (presc_reg[i][1:0] == TCC_DIV4_LAST);
                TCC_M_DIV16: cap_evt[i] = rise[i] && (presc_reg[i] == TCC_DIV16_LAST);
                TCC_M_PERIOD: cap_evt[i] = rise[i];
                TCC_M_PW_FR: begin
                    init_edge[i] = fall[i];
                    cap_evt[i] = (pw_reg[i] == TCC_PW_FIRST) ? (rise[i] | fall[i]) : rise[i];
                end
                TCC_M_PW_RF: begin
                    init_edge[i] = rise[i];
                    cap_evt[i] = (pw_reg[i] == TCC_PW_FIRST) ? (rise[i] | fall[i]) : fall[i];
                end
                TCC_M_CHANGE: cap_evt[i] = rise[i] | fall[i];
                TCC_M_SPEC_FALL: begin
                    if (i == 0) begin
                        spec_evt = fall[i];
                    end
                end
                TCC_M_SPEC_RISE: begin
                    if (i == 0) begin
                        spec_evt = rise[i];
                    end
                end
                default: cap_evt[i] = 1'b0;
            endcase
            if (tcc_is_pw(mode_reg[i])) begin
                rst_req[i] = init_edge[i];
            end else if (i == 0) begin
                rst_req[i] = (cap_evt[i] | spec_evt) & ren_reg[i];
            end else begin
                rst_req[i] = cap_evt[i] & ren_reg[i];
            end
        end
    end

    // ==================================================================
    // Channel state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < TCC_NCH; i++) begin
                presc_reg[i] <= TCC_PRESC_RESET;
                pw_reg[i] <= TCC_PW_FIRST;
            end
        end else begin
            for (int i = 0; i < TCC_NCH; i++) begin
                // Only switching off clears the count; an active mode change keeps it.
                if (mode_reg[i] == TCC_M_OFF) begin
                    presc_reg[i] <= TCC_PRESC_RESET;
                end else if (rise[i] && (mode_reg[i] == TCC_M_DIV4 || mode_reg[i] == TCC_M_DIV16)) begin
                    presc_reg[i] <= presc_reg[i] + 4'h1;
                end
                if (ctrl_wr[i]) begin
                    pw_reg[i] <= TCC_PW_FIRST;
                end else if (tcc_is_pw(mode_reg[i]) && (rise[i] | fall[i])) begin
                    pw_reg[i] <= TCC_PW_ARMED;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < TCC_NCH; i++) begin
                buf_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < TCC_NCH; i++) begin
                if (cap_evt[i]) begin
                    buf_reg[i] <= capture_time_base_i + 16'h0001;
                end
            end
        end
    end

    // Period results are flagged valid from the second capture on.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            seen_reg <= '0;
            valid_reg <= '0;
        end else begin
            for (int i = 0; i < TCC_NCH; i++) begin
                if (ctrl_wr[i]) begin
                    seen_reg[i] <= 1'b0;
                    valid_reg[i] <= 1'b0;
                end else if (cap_evt[i] && mode_reg[i] == TCC_M_PERIOD) begin
                    seen_reg[i] <= 1'b1;
                    valid_reg[i] <= seen_reg[i];
                end
            end
        end
    end

    // Event flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flag_reg <= '0;
        end else begin
            for (int i = 0; i < TCC_NCH; i++) begin
                if (cap_evt[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (wr_pend_reg && wr_addr_reg == TCC_OFF_STAT && hwdata_i[TCC_STAT_FLAG_LSB + i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ==================================================================
    // Time base control and event outputs
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            time_base_reset_o <= 1'b0;
            capture_event_o <= '0;
            special_event_o <= 1'b0;
        end else begin
            // A software write to the counter in the same cycle suppresses the reset.
            time_base_reset_o <= (|rst_req) && !time_base_write_i;
            capture_event_o <= cap_evt;
            special_event_o <= spec_evt;
        end
    end

    // ==================================================================
    // AHB-Lite slave, zero wait states
    assign addr_phase = hsel_i && hready_i && (htrans_i == TCC_HTRANS_NONSEQ || htrans_i == TCC_HTRANS_SEQ);

    always_comb begin
        ctrl_wr = '0;
        for (int i = 0; i < TCC_NCH; i++) begin
            ctrl_wr[i] = wr_pend_reg && (wr_addr_reg == tcc_ctrl_off(i));
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr_i[TCC_ADDR_W-1:0])
            TCC_OFF_CTRL0, TCC_OFF_CTRL1, TCC_OFF_CTRL2: begin
                for (int i = 0; i < TCC_NCH; i++) begin
                    if (haddr_i[TCC_ADDR_W-1:0] == tcc_ctrl_off(i)) begin
                        rd_next[TCC_CTRL_REN_BIT] = ren_reg[i];
                        rd_next[TCC_CTRL_MODE_LSB +: 4] = mode_reg[i];
                    end
                end
            end
            TCC_OFF_BUF0: rd_next[TCC_TB_W-1:0] = buf_reg[0];
            TCC_OFF_BUF1: rd_next[TCC_TB_W-1:0] = buf_reg[1];
            TCC_OFF_BUF2: rd_next[TCC_TB_W-1:0] = buf_reg[2];
            TCC_OFF_STAT: begin
                rd_next[TCC_STAT_FLAG_LSB +: TCC_NCH] = flag_reg;
                rd_next[TCC_STAT_VALID_LSB +: TCC_NCH] = valid_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
        if (haddr_i[31:TCC_ADDR_W] != 24'h00_0000) begin
            rd_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= TCC_HRESP_OKAY;
        end else begin
            wr_pend_reg <= addr_phase && hwrite_i && (haddr_i[31:TCC_ADDR_W] == 24'h00_0000);
            wr_addr_reg <= haddr_i[TCC_ADDR_W-1:0];
            if (addr_phase && !hwrite_i) begin
                hrdata_o <= rd_next;
            end
            hreadyout_o <= 1'b1;
            hresp_o <= TCC_HRESP_OKAY;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ren_reg <= '0;
            for (int i = 0; i < TCC_NCH; i++) begin
                mode_reg[i] <= TCC_MODE_RESET;
            end
        end else begin
            for (int i = 0; i < TCC_NCH; i++) begin
                if (ctrl_wr[i]) begin
                    ren_reg[i] <= hwdata_i[TCC_CTRL_REN_BIT];
                    mode_reg[i] <= hwdata_i[TCC_CTRL_MODE_LSB +: 4];
                end
            end
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_capture0;
        cap_evt[0] && !ctrl_wr[0];
    endsequence

    sequence seq_load0;
        buf_reg[0] == $past(capture_time_base_i) + 16'h0001;
    endsequence

    sequence seq_period_capture2;
        cap_evt[2] && mode_reg[2] == TCC_M_PERIOD && !ctrl_wr[2];
    endsequence

    AST_CAPTURE_LOAD: assert property (seq_capture0 |=> seq_load0)
        else $error("Capture buffer did not load incremented time base.");
    AST_TB_RESET: assert property ((|rst_req) && !time_base_write_i |=> time_base_reset_o)
        else $error("Time base reset missing after capture.");
    AST_WRITE_PRIORITY: assert property (time_base_write_i |=> !time_base_reset_o)
        else $error("Capture reset overrode a time base write.");
    AST_OFF_SILENT: assert property (mode_reg[1] == TCC_M_OFF |-> !cap_evt[1] && !rst_req[1])
        else $error("Channel captured while switched off.");
    AST_PRESC_CLEAR: assert property (ctrl_wr[2] && hwdata_i[3:0] == TCC_M_OFF |=> ##1 presc_reg[2] == 4'h0)
        else $error("Prescaler not cleared when channel switched off.");
    // The capture edge also advances the count, so the low bits must restart at zero.
    AST_DIV4_WRAP: assert property (cap_evt[1] && mode_reg[1] == TCC_M_DIV4 |=> presc_reg[1][1:0] == 2'h0)
        else $error("Divide-by-four counter did not wrap after its capture.");
    // A direct change between active modes keeps the count, so a first capture may come early.
    AST_PRESC_KEEP: assert property (ctrl_wr[1] && mode_reg[1] != TCC_M_OFF && !rise[1]
        |=> presc_reg[1] == $past(presc_reg[1]))
        else $error("Prescaler count lost across an active mode change.");
    AST_PW_RESET: assert property (tcc_is_pw(mode_reg[1]) && init_edge[1] && !time_base_write_i
        |=> time_base_reset_o)
        else $error("Pulse width initiating edge did not reset time base.");
    AST_FLAG_SET: assert property (cap_evt[1] |=> flag_reg[1] [*1] ##0 capture_event_o[1])
        else $error("Capture did not set its channel flag.");
    // A clear that meets a new event in the same cycle must lose.
    AST_FLAG_SET_ZERO: assert property (cap_evt[0] |=> flag_reg[0])
        else $error("Capture next to a clear did not leave its flag set.");
    AST_FLAG_CLEAR: assert property (wr_pend_reg && wr_addr_reg == TCC_OFF_STAT
        && hwdata_i[TCC_STAT_FLAG_LSB] && !cap_evt[0] |=> !flag_reg[0])
        else $error("Event flag not cleared by a write of one.");
    AST_PERIOD_INVALID: assert property (seq_period_capture2 ##0 !seen_reg[2] |=> !valid_reg[2])
        else $error("First period result marked valid.");
    AST_PERIOD_VALID: assert property (seq_period_capture2 ##0 seen_reg[2] |=> valid_reg[2])
        else $error("Second period result not marked valid.");
    AST_SPEC_ONLY_ONE: assert property (spec_evt |-> mode_reg[0] >= TCC_M_SPEC_FALL && !cap_evt[0])
        else $error("Special trigger outside channel one special mode.");
    AST_CTRL_UNUSED_ZERO: assert property (addr_phase && !hwrite_i
        && haddr_i[TCC_ADDR_W-1:0] == TCC_OFF_CTRL0 |=> hrdata_o[7] == 1'b0 && hrdata_o[5:4] == 2'h0)
        else $error("Unimplemented control bits read as one.");
endmodule

// ===== testbench/tcc_line_model.sv
// Behavioural model of the capture pins and of the shared time base counter.
`timescale 1ns/10ps
module tcc_line_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Reset request from the capture block
    input wire logic time_base_reset_i,
    // Pins and time base towards the capture block
    output logic [2:0] capture_input_o,
    output logic [15:0] capture_time_base_o,
    output logic time_base_write_o
);
    logic [15:0] load_value_reg;
    initial begin
        capture_input_o = 3'h0;
        time_base_write_o = 1'b0;
        load_value_reg = 16'h0000;
    end
    // ==================================================================
    // Time base
    // The counter is held still between loads and resets, so that every captured value is exact.
    // Both paths run on the block's own clock, never asynchronously.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            capture_time_base_o <= 16'h0000;
        end else if (time_base_write_o) begin
            capture_time_base_o <= load_value_reg;
        end else if (time_base_reset_i) begin
            capture_time_base_o <= 16'h0000;
        end
    end
    // ==================================================================
    // Stimulus tasks
    task automatic set_pin(input int ch, input logic v);
        @(posedge sys_clk_i);
        capture_input_o[ch] <= v;
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge sys_clk_i);
        load_value_reg <= v;
        time_base_write_o <= 1'b1;
        @(posedge sys_clk_i);
        time_base_write_o <= 1'b0;
    endtask
endmodule

// ===== testbench/tb_tcc_capture.sv
// Self-checking testbench of the three channel capture block.
`timescale 1ns/10ps
module tb_tcc_capture;
    import tcc_pkg::*;
    logic sys_clk_i, sys_rst_i, hwrite, hready, hresp, tb_rst, tb_wr, spec;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] pins, ev;
    logic [15:0] tbase;
    int bad_count, n_compared, spec_cnt, base, sbase;
    int ev_cnt[3];
    logic [31:0] rd;
    logic [3:0] modes[3] = '{4'h1, 4'h2, 4'h8};
    int caps[3] = '{1, 1, 2};

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    tcc_capture dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .capture_input_i(pins),
        .capture_time_base_i(tbase), .time_base_write_i(tb_wr), .time_base_reset_o(tb_rst),
        .capture_event_o(ev), .special_event_o(spec));
    tcc_line_model pm_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .time_base_reset_i(tb_rst),
        .capture_input_o(pins), .capture_time_base_o(tbase), .time_base_write_o(tb_wr));

    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (ev[i] === 1'b1) ev_cnt[i]++;
        end
        if (spec === 1'b1) spec_cnt++;
    end
    // ==================================================================
    // Checking and bus tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ahb_wait();
        do @(posedge sys_clk_i); while (hready !== 1'b1);
    endtask
    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        htrans <= TCC_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= 1'b1;
        ahb_wait();
        htrans <= 2'h0;
        hwdata <= d;
        ahb_wait();
        check("response", {31'h0, hresp}, {31'h0, TCC_HRESP_OKAY});
    endtask
    task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        htrans <= TCC_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= 1'b0;
        ahb_wait();
        htrans <= 2'h0;
        ahb_wait();
        d = hrdata;
    endtask
    task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb_read(a, v);
        check(what, v, exp);
    endtask
    // Each pin change is given time to pass the synchroniser and the capture stage.
    task automatic pin(input int ch, input logic v);
        pm_u.set_pin(ch, v);
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic pulse(input int ch);
        pin(ch, 1'b1);
        pin(ch, 1'b0);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==================================================================
    // Tests
    initial begin
        sys_rst_i = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int c = 0; c < 3; c++) rd_check("control reset", 8'(c * 4), 32'h0);
        ahb_write(TCC_OFF_CTRL0, 32'hFFFF_FFFF);
        rd_check("control mask", TCC_OFF_CTRL0, 32'h0000_004F);
        rd_check("unmapped", 8'h1C, 32'h0);
        ahb_write(TCC_OFF_CTRL0, 32'h0);
        base = ev_cnt[0];
        pulse(0);
        check("off events", ev_cnt[0] - base, 0);
        ahb_write(TCC_OFF_CTRL2, 32'h0000_0049);
        base = ev_cnt[2];
        pulse(2);
        check("unused code events", ev_cnt[2] - base, 0);
        ahb_write(TCC_OFF_CTRL2, 32'h0);
        for (int c = 0; c < 3; c++) begin
            pm_u.load(16'h1230 + 16'(c));
            ahb_write(8'(c * 4), {24'h0, 4'h4, modes[c]});
            base = ev_cnt[c];
            pulse(c);
            check("edge events", ev_cnt[c] - base, caps[c]);
            ahb_read(8'(TCC_OFF_BUF0 + c * 4), rd);
            check("edge buffer", rd[15:0], (c == 2) ? 16'h0001 : 16'h1231 + 16'(c));
            check("time base cleared", tbase, 16'h0000);
            ahb_write(8'(c * 4), 32'h0);
        end
        ahb_read(TCC_OFF_STAT, rd);
        check("event flags", rd[2:0], 3'h7);
        ahb_write(TCC_OFF_STAT, 32'h7);
        ahb_read(TCC_OFF_STAT, rd);
        check("flags cleared", rd[2:0], 3'h0);
        pm_u.load(16'h0500);
        ahb_write(TCC_OFF_CTRL0, {28'h0, TCC_M_RISE});
        pulse(0);
        rd_check("no reset buffer", TCC_OFF_BUF0, 32'h0501);
        check("time base kept", tbase, 16'h0500);
        // The counter write is placed in the very cycle in which the rising edge is decoded.
        ahb_write(TCC_OFF_CTRL0, {24'h0, 4'h4, TCC_M_RISE});
        base = ev_cnt[0];
        fork
            pin(0, 1'b1);
            begin
                repeat (2) @(posedge sys_clk_i);
                pm_u.load(16'h0777);
            end
        join
        check("write beats reset", tbase, 16'h0777);
        check("capture beside write", ev_cnt[0] - base, 1);
        pin(0, 1'b0);
        for (int p = 0; p < 2; p++) begin
            ahb_write(TCC_OFF_CTRL1, 32'h0);
            ahb_write(TCC_OFF_CTRL1, {28'h0, (p == 0) ? TCC_M_DIV4 : TCC_M_DIV16});
            base = ev_cnt[1];
            for (int n = 0; n < ((p == 0) ? 3 : 15); n++) pulse(1);
            check("prescaled early", ev_cnt[1] - base, 0);
            pulse(1);
            check("prescaled wrap", ev_cnt[1] - base, 1);
        end
        // One edge left in the count, then a direct switch to every fourth edge.
        pulse(1);
        ahb_write(TCC_OFF_CTRL1, {28'h0, TCC_M_DIV4});
        base = ev_cnt[1];
        pulse(1);
        pulse(1);
        check("mode change early", ev_cnt[1] - base, 0);
        pulse(1);
        check("mode change kept count", ev_cnt[1] - base, 1);
        ahb_write(TCC_OFF_CTRL1, 32'h0);
        pm_u.load(16'h0100);
        ahb_write(TCC_OFF_CTRL1, {28'h0, TCC_M_PW_RF});
        base = ev_cnt[1];
        pin(1, 1'b1);
        check("width start reset", tbase, 16'h0000);
        check("width first edge", ev_cnt[1] - base, 1);
        pm_u.load(16'h0050);
        pin(1, 1'b0);
        rd_check("width buffer", TCC_OFF_BUF1, 32'h0051);
        check("width end kept", tbase, 16'h0050);
        ahb_write(TCC_OFF_CTRL1, 32'h0);
        pm_u.load(16'h0300);
        ahb_write(TCC_OFF_CTRL1, {28'h0, TCC_M_PW_FR});
        base = ev_cnt[1];
        pin(1, 1'b1);
        check("width first rise", tbase, 16'h0300);
        pin(1, 1'b0);
        check("width fall reset", tbase, 16'h0000);
        check("width fall no capture", ev_cnt[1] - base, 1);
        pm_u.load(16'h0070);
        pin(1, 1'b1);
        rd_check("width rise buffer", TCC_OFF_BUF1, 32'h0071);
        pin(1, 1'b0);
        ahb_write(TCC_OFF_CTRL1, 32'h0);
        ahb_write(TCC_OFF_CTRL2, {24'h0, 4'h4, TCC_M_PERIOD});
        pulse(2);
        ahb_read(TCC_OFF_STAT, rd);
        check("period first", rd[6], 1'b0);
        pulse(2);
        ahb_read(TCC_OFF_STAT, rd);
        check("period valid", rd[6], 1'b1);
        check("period reset", tbase, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            pm_u.load(16'h0200);
            ahb_write(8'((k % 2) * 4), {24'h0, 4'h4, (k < 2) ? TCC_M_SPEC_FALL : TCC_M_SPEC_RISE});
            base = ev_cnt[k % 2];
            sbase = spec_cnt;
            pin(k % 2, 1'b1);
            check("special rising edge", spec_cnt - sbase, (k == 2) ? 1 : 0);
            pin(k % 2, 1'b0);
            check("special trigger", spec_cnt - sbase, (k % 2 == 0) ? 1 : 0);
            check("special no capture", ev_cnt[k % 2] - base, 0);
            check("special reset", tbase, (k % 2 == 0) ? 16'h0000 : 16'h0200);
        end
        report_and_stop();
    end

    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
endmodule
